// >>> src/sba_pkg.sv
// Package: opcodes, field positions and reset values for the SIMD byte/halfword ALU
// Behaviour
// - move_top_halfword writes immediate to bits 31:16, keeps bits 15:0
// - move_top_halfword leaves all flags and lane_sign_flags unchanged
// - byte_swap_word reverses all four bytes of the word
// - byte_swap_halves swaps the bytes inside each halfword independently
// - byte_swap_signed_half swaps bottom halfword bytes, sign-extends to 32 bits
// - bit_mirror_word result bit i equals operand bit 31 minus i
// - Byte-swap and bit-mirror operations leave all flags unaltered
// - parallel_add_halves adds signed halfwords separately, keeps low 16 bits
// - parallel_add_halves flag pairs are 11 for non-negative sums, else 00
// - parallel_add_bytes does four signed 8-bit adds, keeps low 8 bits
// - parallel_add_bytes sets flag bit n when lane n sum is non-negative
// - add_sub_exchange: low = n.lo minus m.hi, high = n.hi plus m.lo
// - add_sub_exchange flag pairs follow difference and sum signs
// - sub_add_exchange: low = n.lo plus m.hi, high = n.hi minus m.lo
// - sub_add_exchange flag pairs follow sum and difference signs
// - byte_pick_by_flags takes lane n from first operand when flag n set
// - A failed condition updates neither destination nor any flag
package sba_pkg;
  localparam int unsigned SBA_WORD_W = 32;
  localparam int unsigned SBA_HALF_W = 16;
  localparam int unsigned SBA_LANES = 4;
  localparam int unsigned SBA_TOP_LSB = 16;
  localparam logic [3:0] SBA_FLAGS_RST = 4'h0;
  localparam logic [31:0] SBA_RES_RST = 32'h0000_0000;

  typedef enum logic [3:0] {
    SBA_OP_MOVE_TOP,
    SBA_OP_SWAP_WORD,
    SBA_OP_SWAP_HALVES,
    SBA_OP_SWAP_SIGNED_HALF,
    SBA_OP_MIRROR,
    SBA_OP_ADD_HALVES,
    SBA_OP_ADD_BYTES,
    SBA_OP_ADD_SUB_X,
    SBA_OP_SUB_ADD_X,
    SBA_OP_PICK
  } sba_op_e;
endpackage

// >>> src/sba_res_if.sv
// Interface: result word and lane flags produced by the datapath units
`timescale 1ns/1ps
`default_nettype none
interface sba_res_if;
  logic [31:0] result;
  logic [3:0] flags;
  logic sets_flags;
  modport src (output result, output flags, output sets_flags);
  modport dst (input result, input flags, input sets_flags);
endinterface
`default_nettype wire

// >>> src/sba_arith.sv
// Parallel signed adds and exchange add/subtract with lane sign results
`timescale 1ns/1ps
`default_nettype none
module sba_arith
  import sba_pkg::*;
(
  input wire sba_op_e op,
  input wire logic [31:0] opa,
  input wire logic [31:0] opb,
  sba_res_if.src res
);
  // 17-bit full-precision signed halfword add or subtract
  function automatic logic [16:0] hs(input logic [15:0] a, input logic [15:0] b,
                                     input logic sub);
    logic [16:0] ax;
    logic [16:0] bx;
    ax = {a[15], a};
    bx = {b[15], b};
    hs = sub ? (ax - bx) : (ax + bx);
  endfunction

  function automatic logic [8:0] bs(input logic [7:0] a, input logic [7:0] b);
    bs = {a[7], a} + {b[7], b};
  endfunction

  wire logic is_xs = (op == SBA_OP_ADD_SUB_X);
  wire logic [15:0] m_lo_sel = (op == SBA_OP_ADD_HALVES) ? opb[15:0] : opb[31:16];
  wire logic [15:0] m_hi_sel = (op == SBA_OP_ADD_HALVES) ? opb[31:16] : opb[15:0];
  // Lower lane subtracts for add_sub_exchange, upper for sub_add_exchange
  wire logic [16:0] lo17 = hs(opa[15:0], m_lo_sel, is_xs);
  wire logic [16:0] hi17 = hs(opa[31:16], m_hi_sel, op == SBA_OP_SUB_ADD_X);
  wire logic [8:0] b0 = bs(opa[7:0], opb[7:0]);
  wire logic [8:0] b1 = bs(opa[15:8], opb[15:8]);
  wire logic [8:0] b2 = bs(opa[23:16], opb[23:16]);
  wire logic [8:0] b3 = bs(opa[31:24], opb[31:24]);

  assign res.sets_flags = (op == SBA_OP_ADD_HALVES) || (op == SBA_OP_ADD_BYTES)
                          || is_xs || (op == SBA_OP_SUB_ADD_X);
  assign res.result = (op == SBA_OP_ADD_BYTES) ? {b3[7:0], b2[7:0], b1[7:0], b0[7:0]}
                                               : {hi17[15:0], lo17[15:0]};
  assign res.flags = (op == SBA_OP_ADD_BYTES)
                     ? {~b3[8], ~b2[8], ~b1[8], ~b0[8]}
                     : {{2{~hi17[16]}}, {2{~lo17[16]}}};
endmodule
`default_nettype wire

// >>> src/sba_perm.sv
// Byte swaps, bit mirror, top-halfword move and flag-driven byte pick
`timescale 1ns/1ps
`default_nettype none
module sba_perm
  import sba_pkg::*;
(
  input wire sba_op_e op,
  input wire logic [31:0] opa,
  input wire logic [31:0] opb,
  input wire logic [15:0] imm,
  input wire logic [31:0] dest_old,
  input wire logic [3:0] lane_flags,
  sba_res_if.src res
);
  logic [31:0] mirror;
  logic [31:0] pick;
  always_comb
  begin
    for (int i = 0; i < 32; i++)
    begin
      mirror[i] = opa[31 - i];
    end
    for (int n = 0; n < 4; n++)
    begin
      pick[8*n +: 8] = lane_flags[n] ? opa[8*n +: 8] : opb[8*n +: 8];
    end
  end

  wire logic [15:0] swapped_lo = {opa[7:0], opa[15:8]};
  // None of these operations touch the lane flags
  assign res.sets_flags = 1'b0;
  assign res.flags = lane_flags;
  assign res.result =
    (op == SBA_OP_MOVE_TOP) ? {imm, dest_old[15:0]} :
    (op == SBA_OP_SWAP_WORD) ? {opa[7:0], opa[15:8], opa[23:16], opa[31:24]} :
    (op == SBA_OP_SWAP_HALVES) ? {opa[23:16], opa[31:24], swapped_lo} :
    (op == SBA_OP_SWAP_SIGNED_HALF) ? {{16{swapped_lo[15]}}, swapped_lo} :
    (op == SBA_OP_MIRROR) ? mirror : pick;
endmodule
`default_nettype wire

// >>> src/sba_alu.sv
// Top: SIMD byte/halfword ALU slice with registered result and lane flags
`timescale 1ns/1ps
`default_nettype none
module sba_alu
  import sba_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic op_valid,
  input wire sba_op_e op,
  input wire logic cond_pass,
  input wire logic [31:0] first_operand,
  input wire logic [31:0] second_operand,
  input wire logic [15:0] imm16,
  input wire logic [31:0] dest_old,
  output logic [31:0] dest_data,
  output logic dest_we,
  output logic [3:0] lane_sign_flags
);
  sba_res_if ar_if ();
  sba_res_if pm_if ();

  logic [31:0] dest_data_q;
  logic dest_we_q;
  logic [3:0] flags_q;

  sba_arith u_arith (
    .op(op),
    .opa(first_operand),
    .opb(second_operand),
    .res(ar_if.src)
  );

  sba_perm u_perm (
    .op(op),
    .opa(first_operand),
    .opb(second_operand),
    .imm(imm16),
    .dest_old(dest_old),
    .lane_flags(flags_q),
    .res(pm_if.src)
  );

  // Destination is checked by the decoder; this slice cannot see register numbers
  wire logic go = op_valid && cond_pass;
  wire logic use_arith = ar_if.sets_flags;
  // Both units report whether they own the flags; only the adder unit ever does
  wire logic flag_op = ar_if.sets_flags || pm_if.sets_flags;
  wire logic [31:0] dest_data_d = use_arith ? ar_if.result : pm_if.result;
  wire logic [3:0] unit_flags = use_arith ? ar_if.flags : pm_if.flags;
  wire logic [3:0] flags_d = (go && flag_op) ? unit_flags : flags_q;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      dest_data_q <= SBA_RES_RST;
      dest_we_q <= 1'b0;
      flags_q <= SBA_FLAGS_RST;
    end
    else
    begin
      dest_data_q <= go ? dest_data_d : dest_data_q;
      dest_we_q <= go;
      flags_q <= flags_d;
    end
  end

  assign dest_data = dest_data_q;
  assign dest_we = dest_we_q;
  assign lane_sign_flags = flags_q;

  // Signed lane values for the checks below, worked in plain integers
  function automatic int sx16(input logic [15:0] x);
    sx16 = int'($signed(x));
  endfunction

  function automatic int sx8(input logic [7:0] x);
    sx8 = int'($signed(x));
  endfunction

  // Low bits of a lane result, cut on purpose from the integer sum
  function automatic logic [15:0] lo16(input int v);
    lo16 = v[15:0];
  endfunction

  function automatic logic [7:0] lo8(input int v);
    lo8 = v[7:0];
  endfunction

  // Flag pair for one halfword lane: both bits follow the sign of the full sum
  function automatic logic [1:0] pair_of(input int v);
    pair_of = (v >= 0) ? 2'b11 : 2'b00;
  endfunction

  sequence s_issue_flagless;
    op_valid && cond_pass && !use_arith;
  endsequence

  sequence s_flags_kept;
    $stable(lane_sign_flags);
  endsequence

  sequence s_issue_move;
    go && op == SBA_OP_MOVE_TOP;
  endsequence

  sequence s_issue_swap_word;
    go && op == SBA_OP_SWAP_WORD;
  endsequence

  sequence s_issue_swap_halves;
    go && op == SBA_OP_SWAP_HALVES;
  endsequence

  sequence s_issue_swap_signed;
    go && op == SBA_OP_SWAP_SIGNED_HALF;
  endsequence

  sequence s_issue_mirror;
    go && op == SBA_OP_MIRROR;
  endsequence

  sequence s_issue_reorder;
    go && (op == SBA_OP_SWAP_WORD || op == SBA_OP_SWAP_HALVES
           || op == SBA_OP_SWAP_SIGNED_HALF || op == SBA_OP_MIRROR);
  endsequence

  sequence s_issue_add_halves;
    go && op == SBA_OP_ADD_HALVES;
  endsequence

  sequence s_issue_add_bytes;
    go && op == SBA_OP_ADD_BYTES;
  endsequence

  sequence s_issue_asx;
    go && op == SBA_OP_ADD_SUB_X;
  endsequence

  sequence s_issue_sax;
    go && op == SBA_OP_SUB_ADD_X;
  endsequence

  sequence s_issue_pick;
    go && op == SBA_OP_PICK;
  endsequence

  a_cond_fail_hold: assert property (@(posedge clock) disable iff (rst)
    (op_valid && !cond_pass) |=> (!dest_we && $stable(lane_sign_flags)))
    else $error("failed condition changed state");
  a_flagless_keep: assert property (@(posedge clock) disable iff (rst)
    s_issue_flagless |=> (dest_we && $stable(lane_sign_flags)))
    else $error("non flag op changed lane flags");
  a_move_top: assert property (@(posedge clock) disable iff (rst)
    (go && op == SBA_OP_MOVE_TOP) |=>
      (dest_data == {$past(imm16), $past(dest_old[15:0])}))
    else $error("move top halfword wrong");
  a_swap_word: assert property (@(posedge clock) disable iff (rst)
    (go && op == SBA_OP_SWAP_WORD) |=>
      (dest_data[7:0] == $past(first_operand[31:24]) &&
       dest_data[31:24] == $past(first_operand[7:0])))
    else $error("byte swap word wrong");
  a_swap_signed: assert property (@(posedge clock) disable iff (rst)
    (go && op == SBA_OP_SWAP_SIGNED_HALF) |=>
      (dest_data[31:16] == {16{$past(first_operand[7])}}))
    else $error("signed half swap extension wrong");
  a_mirror_ends: assert property (@(posedge clock) disable iff (rst)
    (go && op == SBA_OP_MIRROR) |=>
      (dest_data[0] == $past(first_operand[31]) && dest_data[31] == $past(first_operand[0])))
    else $error("bit mirror wrong");
  a_add_halves: assert property (@(posedge clock) disable iff (rst)
    (go && op == SBA_OP_ADD_HALVES) |=>
      (lane_sign_flags[1] == lane_sign_flags[0] && lane_sign_flags[3] == lane_sign_flags[2]
       && dest_data[15:0] == 16'($past(first_operand[15:0]) + $past(second_operand[15:0]))))
    else $error("parallel halfword add wrong");
  a_pick_bytes: assert property (@(posedge clock) disable iff (rst)
    (go && op == SBA_OP_PICK) |=>
      (dest_data[7:0] == ($past(flags_q[0]) ? $past(first_operand[7:0])
                                            : $past(second_operand[7:0]))))
    else $error("byte pick wrong");

  // Reordering and the top move must never disturb flags set by an earlier add
  a_move_flags: assert property (@(posedge clock) disable iff (rst)
    s_issue_move |=> s_flags_kept)
    else $error("move top halfword changed lane flags");

  a_reorder_flags: assert property (@(posedge clock) disable iff (rst)
    s_issue_reorder |=> s_flags_kept)
    else $error("byte reorder changed lane flags");

  a_swap_word_mid: assert property (@(posedge clock) disable iff (rst)
    s_issue_swap_word |=>
      (dest_data[15:8] == $past(first_operand[23:16]) &&
       dest_data[23:16] == $past(first_operand[15:8])))
    else $error("byte swap word middle bytes wrong");

  a_swap_halves: assert property (@(posedge clock) disable iff (rst)
    s_issue_swap_halves |=>
      (dest_data == {$past(first_operand[23:16]), $past(first_operand[31:24]),
                     $past(first_operand[7:0]), $past(first_operand[15:8])}))
    else $error("byte swap halves wrong");

  a_swap_signed_low: assert property (@(posedge clock) disable iff (rst)
    s_issue_swap_signed |=>
      (dest_data[15:0] == {$past(first_operand[7:0]), $past(first_operand[15:8])}))
    else $error("signed half swap bytes wrong");

  a_mirror_mid: assert property (@(posedge clock) disable iff (rst)
    s_issue_mirror |=>
      (dest_data[15] == $past(first_operand[16])
       && dest_data[16] == $past(first_operand[15])
       && dest_data[7] == $past(first_operand[24])
       && dest_data[24] == $past(first_operand[7])))
    else $error("bit mirror inner bits wrong");

  // Integer references catch a carry that leaks between lanes or a lost sign bit
  a_add_halves_hi: assert property (@(posedge clock) disable iff (rst)
    s_issue_add_halves |=>
      (dest_data[31:16] == lo16(sx16($past(first_operand[31:16]))
                                + sx16($past(second_operand[31:16])))))
    else $error("parallel halfword add upper lane wrong");

  a_half_flags: assert property (@(posedge clock) disable iff (rst)
    s_issue_add_halves |=>
      (lane_sign_flags[1:0] == pair_of(sx16($past(first_operand[15:0]))
                                       + sx16($past(second_operand[15:0])))
       && lane_sign_flags[3:2] == pair_of(sx16($past(first_operand[31:16]))
                                          + sx16($past(second_operand[31:16])))))
    else $error("parallel halfword add flags wrong");

  a_add_bytes_lo: assert property (@(posedge clock) disable iff (rst)
    s_issue_add_bytes |=>
      (dest_data[7:0] == lo8(sx8($past(first_operand[7:0]))
                             + sx8($past(second_operand[7:0])))
       && dest_data[15:8] == lo8(sx8($past(first_operand[15:8]))
                                 + sx8($past(second_operand[15:8])))))
    else $error("parallel byte add low lanes wrong");

  a_add_bytes_hi: assert property (@(posedge clock) disable iff (rst)
    s_issue_add_bytes |=>
      (dest_data[23:16] == lo8(sx8($past(first_operand[23:16]))
                               + sx8($past(second_operand[23:16])))
       && dest_data[31:24] == lo8(sx8($past(first_operand[31:24]))
                                  + sx8($past(second_operand[31:24])))))
    else $error("parallel byte add high lanes wrong");

  a_byte_flags: assert property (@(posedge clock) disable iff (rst)
    s_issue_add_bytes |=>
      (lane_sign_flags[0] == (sx8($past(first_operand[7:0]))
                              + sx8($past(second_operand[7:0])) >= 0)
       && lane_sign_flags[1] == (sx8($past(first_operand[15:8]))
                                 + sx8($past(second_operand[15:8])) >= 0)
       && lane_sign_flags[2] == (sx8($past(first_operand[23:16]))
                                 + sx8($past(second_operand[23:16])) >= 0)
       && lane_sign_flags[3] == (sx8($past(first_operand[31:24]))
                                 + sx8($past(second_operand[31:24])) >= 0)))
    else $error("parallel byte add flags wrong");

  a_asx_result: assert property (@(posedge clock) disable iff (rst)
    s_issue_asx |=>
      (dest_data[15:0] == lo16(sx16($past(first_operand[15:0]))
                               - sx16($past(second_operand[31:16])))
       && dest_data[31:16] == lo16(sx16($past(first_operand[31:16]))
                                   + sx16($past(second_operand[15:0])))))
    else $error("add subtract exchange result wrong");

  a_asx_flags: assert property (@(posedge clock) disable iff (rst)
    s_issue_asx |=>
      (lane_sign_flags[1:0] == pair_of(sx16($past(first_operand[15:0]))
                                       - sx16($past(second_operand[31:16])))
       && lane_sign_flags[3:2] == pair_of(sx16($past(first_operand[31:16]))
                                          + sx16($past(second_operand[15:0])))))
    else $error("add subtract exchange flags wrong");

  a_sax_result: assert property (@(posedge clock) disable iff (rst)
    s_issue_sax |=>
      (dest_data[15:0] == lo16(sx16($past(first_operand[15:0]))
                               + sx16($past(second_operand[31:16])))
       && dest_data[31:16] == lo16(sx16($past(first_operand[31:16]))
                                   - sx16($past(second_operand[15:0])))))
    else $error("subtract add exchange result wrong");

  a_sax_flags: assert property (@(posedge clock) disable iff (rst)
    s_issue_sax |=>
      (lane_sign_flags[1:0] == pair_of(sx16($past(first_operand[15:0]))
                                       + sx16($past(second_operand[31:16])))
       && lane_sign_flags[3:2] == pair_of(sx16($past(first_operand[31:16]))
                                          - sx16($past(second_operand[15:0])))))
    else $error("subtract add exchange flags wrong");

  // The pick reads the flags as they stood when it was issued
  a_pick_upper: assert property (@(posedge clock) disable iff (rst)
    s_issue_pick |=>
      (dest_data[31:24] == ($past(flags_q[3]) ? $past(first_operand[31:24])
                                              : $past(second_operand[31:24]))))
    else $error("byte pick upper lane wrong");

  a_write_pulse: assert property (@(posedge clock) disable iff (rst)
    go |=> dest_we)
    else $error("passed operation gave no write");

  a_no_issue_hold: assert property (@(posedge clock) disable iff (rst)
    !go |=> (!dest_we && $stable(dest_data)))
    else $error("destination changed without a passed operation");

  a_flags_persist: assert property (@(posedge clock) disable iff (rst)
    !(go && flag_op) |=> s_flags_kept)
    else $error("lane flags moved without a flag setting operation");
endmodule
`default_nettype wire

// >>> verif/sba_regfile_model.sv
// Destination register model standing in for the core's register file
`timescale 1ns/1ps
`default_nettype none
module sba_regfile_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic [31:0] dest_data,
  input wire logic dest_we,
  output logic [31:0] dest_old
);
  // One general register only, so stack and program pointers are never named
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      dest_old <= 32'h0000_0000;
    else if (dest_we)
      dest_old <= dest_data;
  end
endmodule
`default_nettype wire

// >>> verif/sba_alu_tb.sv
// Self-checking bench for the SIMD byte/halfword ALU
`timescale 1ns/1ps
`default_nettype none
module sba_alu_tb;
  import sba_pkg::*;
  logic clock = 0, rst = 1, op_valid = 0, cond_pass = 0, dest_we;
  sba_op_e op = SBA_OP_MIRROR;
  logic [31:0] first_operand = 0, second_operand = 0, dest_old, dest_data;
  logic [15:0] imm16 = 0;
  logic [3:0] lane_sign_flags, exp_flags = 0;
  logic [31:0] exp_reg = 0;
  logic [35:0] exp_q[$];
  int n_fail = 0, compares = 0, seed = 10, i;
  sba_alu DUT (.clock(clock), .rst(rst), .op_valid(op_valid), .op(op), .cond_pass(cond_pass),
    .first_operand(first_operand), .second_operand(second_operand), .imm16(imm16),
    .dest_old(dest_old), .dest_data(dest_data), .dest_we(dest_we),
    .lane_sign_flags(lane_sign_flags));
  sba_regfile_model rf (.clock(clock), .rst(rst), .dest_data(dest_data), .dest_we(dest_we),
    .dest_old(dest_old));
  initial forever #10 clock = ~clock;
  function automatic logic [16:0] sx(input logic [15:0] x);
    return {x[15], x};
  endfunction
  // Reference: flags in 35:32, result in 31:0
  function automatic logic [35:0] model(input sba_op_e o, input logic [31:0] a, b,
    input logic [15:0] im, input logic [31:0] old, input logic [3:0] f);
    logic [16:0] lo, hi;
    logic [8:0] s;
    logic [31:0] r;
    logic [3:0] nf;
    r = 0;
    nf = f;
    lo = sx(a[15:0]) + sx(b[15:0]);
    hi = sx(a[31:16]) + sx(b[31:16]);
    if (o == SBA_OP_ADD_SUB_X)
    begin
      lo = sx(a[15:0]) - sx(b[31:16]);
      hi = sx(a[31:16]) + sx(b[15:0]);
    end
    if (o == SBA_OP_SUB_ADD_X)
    begin
      lo = sx(a[15:0]) + sx(b[31:16]);
      hi = sx(a[31:16]) - sx(b[15:0]);
    end
    case (o)
      SBA_OP_MOVE_TOP: r = {im, old[15:0]};
      SBA_OP_SWAP_WORD: r = {a[7:0], a[15:8], a[23:16], a[31:24]};
      SBA_OP_SWAP_HALVES: r = {a[23:16], a[31:24], a[7:0], a[15:8]};
      SBA_OP_SWAP_SIGNED_HALF: r = {{16{a[7]}}, a[7:0], a[15:8]};
      SBA_OP_MIRROR: for (int k = 0; k < 32; k++) r[k] = a[31-k];
      SBA_OP_ADD_BYTES:
        for (int k = 0; k < 4; k++)
        begin
          s = {a[8*k+7], a[8*k+:8]} + {b[8*k+7], b[8*k+:8]};
          r[8*k+:8] = s[7:0];
          nf[k] = !s[8];
        end
      SBA_OP_PICK: for (int k = 0; k < 4; k++) r[8*k+:8] = f[k] ? a[8*k+:8] : b[8*k+:8];
      default:
      begin
        r = {hi[15:0], lo[15:0]};
        nf = {{2{!hi[16]}}, {2{!lo[16]}}};
      end
    endcase
    return {nf, r};
  endfunction
  task automatic check(input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic idle();
    @(posedge clock);
    op_valid <= 1'b0;
  endtask
  // Move-top reads the destination's old value, so let the last write land first
  task automatic go(input sba_op_e o, input logic [31:0] a, b, input logic [15:0] im,
    input logic c);
    logic [35:0] m;
    if (o == SBA_OP_MOVE_TOP)
    begin
      idle();
      idle();
    end
    @(posedge clock);
    op_valid <= 1'b1;
    op <= o;
    first_operand <= a;
    second_operand <= b;
    imm16 <= im;
    cond_pass <= c;
    m = model(o, a, b, im, exp_reg, exp_flags);
    if (c)
    begin
      exp_q.push_back(m);
      exp_reg = m[31:0];
      exp_flags = m[35:32];
    end
  endtask
  always @(posedge clock)
  begin
    if (dest_we === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(32'h0000_0001, 32'h0000_0000);
      else
      begin
        check(dest_data, exp_q[0][31:0]);
        check({28'h000_0000, lane_sign_flags}, {28'h000_0000, exp_q[0][35:32]});
        void'(exp_q.pop_front());
      end
    end
  end
  task automatic results();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    go(SBA_OP_ADD_HALVES, 32'h7fff_8000, 32'h0001_ffff, 16'h0000, 1);
    go(SBA_OP_PICK, 32'h1122_3344, 32'h5566_7788, 16'h0000, 1);
    go(SBA_OP_ADD_BYTES, 32'h7f80_0180, 32'h0180_ff80, 16'h0000, 1);
    go(SBA_OP_PICK, 32'h1122_3344, 32'h5566_7788, 16'h0000, 1);
    go(SBA_OP_ADD_SUB_X, 32'h8000_0001, 32'h0002_ffff, 16'h0000, 1);
    go(SBA_OP_SUB_ADD_X, 32'h8000_0001, 32'h0002_0001, 16'h0000, 1);
    go(SBA_OP_ADD_HALVES, 32'hffff_ffff, 32'hffff_ffff, 16'h0000, 0);
    go(SBA_OP_PICK, 32'haaaa_aaaa, 32'h5555_5555, 16'h0000, 1);
    go(SBA_OP_MOVE_TOP, 32'h0000_0000, 32'h0000_0000, 16'hf123, 1);
    go(SBA_OP_MOVE_TOP, 32'h0000_0000, 32'h0000_0000, 16'h0bad, 0);
    for (i = 1; i < 5; i++) go(sba_op_e'(i), 32'h1234_80f1, 32'h0000_0000, 16'h0000, 1);
    $display("test directed done");
    for (i = 0; i < 400; i++)
      go(sba_op_e'(($random(seed) & 32'h7fff_ffff) % 10), $random(seed), $random(seed),
        16'($random(seed)), 1'($random(seed)));
    idle();
    $display("test random done");
    for (i = 0; i < 10 && exp_q.size() != 0; i++) @(posedge clock);
    if (exp_q.size() != 0) n_fail++;
    results();
  end
endmodule
`default_nettype wire
